// ===== core/csc_core.sv
// Colour space converter: stream datapath and register slave
//
// Design decisions made here: register access over Wishbone and the placing of the registers.
`timescale 1ns/10ps
module csc_core
  import csc_pkg::*;
#(
  parameter bit       PARALLEL     = 1'b0,
  parameter int       IN_W         = 8,
  parameter bit       IN_SIGNED    = 1'b0,
  parameter int       OUT_W        = 8,
  parameter bit       OUT_SIGNED   = 1'b0,
  parameter bit       OUT_GUARD    = 1'b0,
  parameter int       OUT_MIN      = 0,
  parameter int       OUT_MAX      = 255,
  parameter int       CW           = 18,
  parameter int       FRAC         = 8,
  parameter int       SHIFT        = 0,
  parameter csc_rnd_t RND_MODE     = RND_TRUNC,
  parameter csc_neg_t NEG_MODE     = NEG_SAT,
  parameter bit       RUNTIME_LOAD = 1'b1,
  parameter int       PRESET_SEL   = 0,
  parameter logic [N_CONST*32-1:0]          CONST_INIT = CONST_INIT_DEF,
  parameter logic [N_PRESET*N_CONST*32-1:0] PRESET_TBL = '0,
  localparam int IN_DW  = PARALLEL ? 3 * IN_W : IN_W,
  localparam int OUT_DW = PARALLEL ? 3 * OUT_W : OUT_W
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // Stream in
  input  wire logic [IN_DW-1:0]  din_data_i,
  input  wire logic              din_valid_i,
  input  wire logic              din_sop_i,
  input  wire logic              din_eop_i,
  output logic                   din_ready_o,
  // Stream out
  output logic      [OUT_DW-1:0] dout_data_o,
  output logic                   dout_valid_o,
  output logic                   dout_sop_o,
  output logic                   dout_eop_o,
  input  wire logic              dout_ready_i
);

  // Products, three-term sum and summand all fit
  localparam int ACC_W = IN_W + CW + 3;

  // Round a Q16 word to the constant format
  function automatic logic [CW-1:0] rnd_c(input logic [31:0] w);
    logic signed [32:0] t;
    t = $signed({w[31], w});
    if (SW_FRAC > FRAC) begin
      t = t + (33'sd1 <<< (SW_FRAC - FRAC - 1));
    end
    t = t >>> (SW_FRAC - FRAC);
    return t[CW-1:0];
  endfunction

  // Wishbone slave
  logic        ack_r;
  logic [31:0] rdat_r;
  logic        req;
  logic        wr;
  logic        ld_preset;
  logic [31:0] rdata;
  logic [3:0]  ctrl_r;
  logic [15:0] pix_cnt_r;
  logic [N_CONST-1:0][CW-1:0] k_all;

  assign req = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr = req & wb_we_i & RUNTIME_LOAD;
  assign ld_preset = wr & (wb_adr_i == ADR_CTRL) & wb_sel_i[0] &
                     (wb_dat_i[3:0] != PRESET_CUSTOM) & (wb_dat_i[3:0] <= 4'(N_PRESET));

  // Coefficients A0..C2 then summands, one register each
  genvar gi;
  generate
    for (gi = 0; gi < N_CONST; gi++) begin : g_k
      localparam int PS = (PRESET_SEL == 0) ? 0 : PRESET_SEL - 1;
      localparam logic [31:0] INIT_W = (PRESET_SEL == 0) ? CONST_INIT[gi*32+:32] :
                                       PRESET_TBL[(PS*N_CONST+gi)*32+:32];
      logic [CW-1:0] k_r;
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          k_r <= rnd_c(INIT_W);
        end else if (ld_preset) begin
          k_r <= rnd_c(PRESET_TBL[(int'(wb_dat_i[3:0])-1)*N_CONST*32+gi*32+:32]);
        end else if (wr && wb_adr_i == ADR_CONST0 + 8'(4 * gi) && &wb_sel_i) begin
          k_r <= rnd_c(wb_dat_i);
        end
      end
      assign k_all[gi] = k_r;
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RST;
    end else if (ld_preset) begin
      ctrl_r <= wb_dat_i[3:0];
    end else if (wr && wb_adr_i == ADR_CTRL && wb_sel_i[0]) begin
      ctrl_r <= PRESET_CUSTOM;
    end else if (wr && wb_adr_i < ADR_CTRL) begin
      ctrl_r <= PRESET_CUSTOM;
    end
  end

  csc_pstate_t state_r;

  // Read mux; unmapped addresses answer zero
  always_comb begin
    rdata = 32'h0000_0000;
    if (wb_adr_i[1:0] == 2'b00) begin
      if (wb_adr_i < ADR_CTRL) begin
        rdata = 32'($signed(k_all[wb_adr_i[5:2]])) << (SW_FRAC - FRAC);
      end else if (wb_adr_i == ADR_CTRL) begin
        rdata = {28'h0000000, ctrl_r};
      end else if (wb_adr_i == ADR_STAT) begin
        rdata = {pix_cnt_r, 15'h0000, state_r == PS_VID};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r <= req;
      if (req) begin
        rdat_r <= rdata;
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // Input skid keeps ready registered without losing a beat
  logic             rdy_r;
  logic             sk_v_r;
  logic [IN_DW-1:0] sk_data_r;
  logic             sk_sop_r;
  logic             sk_eop_r;
  logic             adv;
  logic             p_v;
  logic [IN_DW-1:0] p_data;
  logic             p_sop;
  logic             p_eop;
  logic             take;

  assign p_v = sk_v_r | (rdy_r & din_valid_i);
  assign p_data = sk_v_r ? sk_data_r : din_data_i;
  assign p_sop = sk_v_r ? sk_sop_r : din_sop_i;
  assign p_eop = sk_v_r ? sk_eop_r : din_eop_i;
  assign take = p_v & adv;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sk_v_r <= 1'b0;
      rdy_r <= 1'b0;
    end else if (sk_v_r) begin
      sk_v_r <= ~adv;
      rdy_r <= adv;
    end else begin
      sk_v_r <= rdy_r & din_valid_i & ~adv;
      rdy_r <= ~(rdy_r & din_valid_i & ~adv);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rdy_r && din_valid_i && !sk_v_r) begin
      sk_data_r <= din_data_i;
      sk_sop_r <= din_sop_i;
      sk_eop_r <= din_eop_i;
    end
  end

  assign din_ready_o = rdy_r;

  // Packet parser; control packets pass untouched
  logic is_vid;

  assign is_vid = p_v & ~p_sop & (state_r == PS_VID);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= PS_HDR;
    end else if (take) begin
      case (state_r)
        PS_HDR, PS_VID, PS_OTHER: begin
          if (p_eop) begin
            state_r <= PS_HDR;
          end else if (p_sop) begin
            state_r <= (p_data[3:0] == PKT_VIDEO) ? PS_VID : PS_OTHER;
          end
        end
        default: state_r <= PS_HDR;
      endcase
    end
  end

  // Channel gathering
  logic [1:0]      ch_r;
  logic [IN_W-1:0] c0_r;
  logic [IN_W-1:0] c1_r;
  logic [IN_W-1:0] ch_in [3];
  logic            pix_done;
  logic [1:0]      nb;

  generate
    if (PARALLEL) begin : g_par
      for (gi = 0; gi < 3; gi++) begin : g_sl
        assign ch_in[gi] = p_data[gi*IN_W+:IN_W];
      end
      assign pix_done = is_vid;
      assign nb = 2'd1;
    end else begin : g_seq
      // Short final pixel is padded with zero channels
      assign ch_in[0] = (ch_r == 2'd0) ? p_data : c0_r;
      assign ch_in[1] = (ch_r == 2'd1) ? p_data : ((ch_r == 2'd2) ? c1_r : '0);
      assign ch_in[2] = (ch_r == 2'd2) ? p_data : '0;
      assign pix_done = is_vid & ((ch_r == 2'd2) | p_eop);
      assign nb = ch_r + 2'd1;
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ch_r <= 2'd0;
    end else if (take) begin
      if (!is_vid || pix_done) begin
        ch_r <= 2'd0;
      end else begin
        ch_r <= ch_r + 2'd1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (take && is_vid && ch_r == 2'd0) begin
      c0_r <= p_data[IN_W-1:0];
    end
    if (take && is_vid && ch_r == 2'd1) begin
      c1_r <= p_data[IN_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pix_cnt_r <= PIXCNT_RST;
    end else if (take && p_sop) begin
      pix_cnt_r <= PIXCNT_RST;
    end else if (take && pix_done) begin
      pix_cnt_r <= pix_cnt_r + 16'd1;
    end
  end

  // Matrix multiply and sum
  logic signed [IN_W:0]    x [3];
  logic signed [ACC_W-1:0] acc_c [3];

  generate
    for (gi = 0; gi < 3; gi++) begin : g_mac
      assign x[gi] = $signed({IN_SIGNED & ch_in[gi][IN_W-1], ch_in[gi]});
      assign acc_c[gi] = ACC_W'(x[0]) * ACC_W'($signed(k_all[gi])) +
                         ACC_W'(x[1]) * ACC_W'($signed(k_all[3+gi])) +
                         ACC_W'(x[2]) * ACC_W'($signed(k_all[6+gi])) +
                         ACC_W'($signed(k_all[N_COEF+gi]));
    end
  endgenerate

  // Stage 1: sums or pass beat
  logic              v1_r;
  logic              pix1_r;
  logic              sop1_r;
  logic              eop1_r;
  logic [1:0]        nb1_r;
  logic [OUT_DW-1:0] pd1_r;
  logic signed [ACC_W-1:0] acc1_r [3];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      v1_r <= 1'b0;
    end else if (adv) begin
      v1_r <= take & (~is_vid | pix_done);
    end
  end

  always_ff @(posedge clk_i) begin
    if (adv) begin
      pix1_r <= is_vid;
      sop1_r <= p_sop;
      eop1_r <= p_eop;
      nb1_r <= nb;
      pd1_r <= OUT_DW'(p_data);
      acc1_r <= acc_c;
    end
  end

  // Stage 2: converted results
  logic              v2_r;
  logic              pix2_r;
  logic              sop2_r;
  logic              eop2_r;
  logic [1:0]        nb2_r;
  logic [OUT_DW-1:0] pd2_r;
  logic [OUT_W-1:0]  res_c [3];
  logic [OUT_W-1:0]  res2_r [3];

  generate
    for (gi = 0; gi < 3; gi++) begin : g_cv
      csc_conv #(
        .ACC_W      (ACC_W),
        .FRAC       (FRAC),
        .OUT_W      (OUT_W),
        .SHIFT      (SHIFT),
        .RND_MODE   (RND_MODE),
        .NEG_MODE   (NEG_MODE),
        .OUT_SIGNED (OUT_SIGNED),
        .OUT_GUARD  (OUT_GUARD),
        .OUT_MIN    (OUT_MIN),
        .OUT_MAX    (OUT_MAX)
      ) u_conv (
        .acc_i (acc1_r[gi]),
        .res_o (res_c[gi])
      );
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      v2_r <= 1'b0;
    end else if (adv) begin
      v2_r <= v1_r;
    end
  end

  always_ff @(posedge clk_i) begin
    if (adv) begin
      pix2_r <= pix1_r;
      sop2_r <= sop1_r;
      eop2_r <= eop1_r;
      nb2_r <= nb1_r;
      pd2_r <= pd1_r;
      res2_r <= res_c;
    end
  end

  // Output and channel serialiser
  logic             ov_r;
  logic [OUT_DW-1:0] od_r;
  logic             osop_r;
  logic             oeop_r;
  logic [1:0]       rem_r;
  logic             heop_r;
  logic [OUT_W-1:0] h1_r;
  logic [OUT_W-1:0] h2_r;
  logic             out_go;

  assign out_go = ~ov_r | dout_ready_i;
  // Pipeline halts while stage 2 holds a beat that the stalled output or busy serialiser cannot take
  assign adv = ~v2_r | (out_go & (rem_r == 2'd0));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ov_r <= 1'b0;
      rem_r <= 2'd0;
      osop_r <= 1'b0;
      oeop_r <= 1'b0;
    end else if (out_go) begin
      if (rem_r != 2'd0) begin
        ov_r <= 1'b1;
        osop_r <= 1'b0;
        oeop_r <= heop_r & (rem_r == 2'd1);
        rem_r <= rem_r - 2'd1;
      end else if (v2_r) begin
        ov_r <= 1'b1;
        osop_r <= sop2_r;
        oeop_r <= eop2_r & (~pix2_r | (nb2_r == 2'd1));
        rem_r <= pix2_r ? nb2_r - 2'd1 : 2'd0;
      end else begin
        ov_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      od_r <= '0;
    end else if (out_go && rem_r != 2'd0) begin
      od_r <= OUT_DW'(h1_r);
    end else if (out_go && v2_r && !pix2_r) begin
      od_r <= pd2_r;
    end else if (out_go && v2_r) begin
      od_r <= OUT_DW'({res2_r[2], res2_r[1], res2_r[0]});
    end
  end

  always_ff @(posedge clk_i) begin
    if (out_go && rem_r != 2'd0) begin
      h1_r <= h2_r;
    end else if (out_go && v2_r) begin
      h1_r <= res2_r[1];
      h2_r <= res2_r[2];
      heop_r <= eop2_r;
    end
  end

  assign dout_valid_o = ov_r;
  assign dout_data_o = od_r;
  assign dout_sop_o = osop_r;
  assign dout_eop_o = oeop_r;

endmodule

// ===== common/csc_pkg.sv
// Shared constants and types for the colour space converter
// Overview of operation
// - Signed or unsigned samples, 4 to 20 bits
// - Converted pixels never leave guard band range
// - Nine coefficients, three summands, build or runtime
// - Channel k is matrix column k plus summand
// - Twelve preset matrices besides custom constants
// - Sequential beats are channels 0, 1, 2
// - Parallel channel 0 in lowest slice
// - Constants rounded to fixed point before use
// - Internal widths lose no precision
// - Scale, round, unsign, then clamp
// - Binary point moved by shift, -16..+16
// - Truncate rounds toward negative infinity
// - Half up sends 0.5 upward
// - Half even sends 0.5 to even
// - Negatives saturate or take absolute value
// - Clamp to guard band or width limits
// - Convert until end of packet, pass mismatches
// - Stall only when output stalls or serialiser is busy, short latency
package csc_pkg;

  // Software writes constants with this many fraction bits
  localparam int SW_FRAC = 16;
  localparam int N_COEF = 9;
  localparam int N_CONST = 12;
  localparam int N_PRESET = 12;

  // Register byte offsets
  localparam logic [7:0] ADR_CONST0 = 8'h00;
  localparam logic [7:0] ADR_CTRL = 8'h30;
  localparam logic [7:0] ADR_STAT = 8'h34;

  // Reset values
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [15:0] PIXCNT_RST = 16'h0000;
  localparam logic [3:0] PRESET_CUSTOM = 4'h0;

  // Packet type nibble of a video data packet
  localparam logic [3:0] PKT_VIDEO = 4'h0;

  // Identity matrix, zero summands, Q16 words, entry 0 lowest
  localparam logic [N_CONST*32-1:0] CONST_INIT_DEF = {
    32'h00000000, 32'h00000000, 32'h00000000, 32'h00010000,
    32'h00000000, 32'h00000000, 32'h00000000, 32'h00010000,
    32'h00000000, 32'h00000000, 32'h00000000, 32'h00010000};

  typedef enum logic [2:0] {
    RND_TRUNC     = 3'b001,
    RND_HALF_UP   = 3'b010,
    RND_HALF_EVEN = 3'b100
  } csc_rnd_t;

  typedef enum logic [1:0] {
    NEG_SAT = 2'b01,
    NEG_ABS = 2'b10
  } csc_neg_t;

  typedef enum logic [2:0] {
    PS_HDR   = 3'b001,
    PS_VID   = 3'b010,
    PS_OTHER = 3'b100
  } csc_pstate_t;

endpackage

// ===== core/csc_conv.sv
// Result conversion of one channel to the output integer type
`timescale 1ns/10ps
module csc_conv
  import csc_pkg::*;
#(
  parameter int       ACC_W      = 29,
  parameter int       FRAC       = 8,
  parameter int       OUT_W      = 8,
  parameter int       SHIFT      = 0,
  parameter csc_rnd_t RND_MODE   = RND_TRUNC,
  parameter csc_neg_t NEG_MODE   = NEG_SAT,
  parameter bit       OUT_SIGNED = 1'b0,
  parameter bit       OUT_GUARD  = 1'b0,
  parameter int       OUT_MIN    = 0,
  parameter int       OUT_MAX    = 255
) (
  // Fixed point result in
  input  wire logic signed [ACC_W-1:0] acc_i,
  // Integer result out
  output logic             [OUT_W-1:0] res_o
);

  localparam int W2 = ACC_W + 18;
  localparam int EF = FRAC - SHIFT;
  localparam int LO = OUT_GUARD ? OUT_MIN : (OUT_SIGNED ? -(2 ** (OUT_W - 1)) : 0);
  localparam int HI = OUT_GUARD ? OUT_MAX : (OUT_SIGNED ? 2 ** (OUT_W - 1) - 1 : 2 ** OUT_W - 1);
  localparam logic signed [W2-1:0] LO_W = W2'(LO);
  localparam logic signed [W2-1:0] HI_W = W2'(HI);

  logic signed [W2-1:0] x;
  logic signed [W2-1:0] rnd;
  logic signed [W2-1:0] pos;
  logic signed [W2-1:0] sat;

  // Extra headroom keeps left shift and negation exact
  assign x = W2'(acc_i);

  // Scaling only moves the binary point, so no multiplier
  generate
    if (EF <= 0) begin : g_noint
      assign rnd = x <<< (-EF);
    end else begin : g_frac
      localparam logic [W2-1:0] MASK = (W2'(1) << (EF - 1)) - W2'(1);
      logic signed [W2-1:0] fl;
      logic                 half;
      logic                 rest;
      assign fl = x >>> EF;
      assign half = x[EF-1];
      assign rest = |(x & MASK);
      always_comb begin
        case (RND_MODE)
          RND_TRUNC:     rnd = fl;
          RND_HALF_UP:   rnd = fl + W2'(half);
          RND_HALF_EVEN: rnd = fl + W2'(half & (rest | fl[0]));
          default:       rnd = fl;
        endcase
      end
    end
  endgenerate

  // Order is scale, round, unsign, clamp
  always_comb begin
    pos = rnd;
    if (!OUT_SIGNED && rnd < 0 && NEG_MODE == NEG_ABS) begin
      pos = -rnd;
    end
  end

  // Saturating mode relies on the clamp floor
  always_comb begin
    if (pos < LO_W) begin
      sat = LO_W;
    end else if (pos > HI_W) begin
      sat = HI_W;
    end else begin
      sat = pos;
    end
  end

  assign res_o = sat[OUT_W-1:0];

endmodule

// ===== tb/csc_chk.sv
// Port assertions for the colour space converter
`timescale 1ns/10ps
module csc_chk
  import csc_pkg::*;
#(
  parameter bit  PARALLEL  = 1'b0,
  parameter int  IN_W      = 8,
  parameter int  OUT_W     = 8,
  parameter bit  OUT_GUARD = 1'b0,
  parameter int  OUT_MIN   = 0,
  parameter int  OUT_MAX   = 255,
  localparam int IN_DW     = PARALLEL ? 3 * IN_W : IN_W,
  localparam int OUT_DW    = PARALLEL ? 3 * OUT_W : OUT_W
) (
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [7:0]        wb_adr_i,
  input wire logic [31:0]       wb_dat_o,
  input wire logic              wb_ack_o,
  input wire logic              din_valid_i,
  input wire logic              din_ready_o,
  input wire logic [OUT_DW-1:0] dout_data_o,
  input wire logic              dout_valid_o,
  input wire logic              dout_sop_o,
  input wire logic              dout_eop_o,
  input wire logic              dout_ready_i
);
  // Unsigned output assumed for the width limits
  localparam int LO = OUT_GUARD ? OUT_MIN : 0;
  localparam int HI = OUT_GUARD ? OUT_MAX : (1 << OUT_W) - 1;
  logic vid_r;

  // Tracks pixel beats of a video packet on the output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vid_r <= 1'b0;
    end else if (dout_valid_o && dout_ready_i) begin
      vid_r <= dout_sop_o ? (dout_data_o[3:0] == 4'h0 && !dout_eop_o) : (vid_r && !dout_eop_o);
    end
  end

  function automatic bit in_rng(logic [OUT_DW-1:0] d);
    in_rng = 1'b1;
    for (int k = 0; k < OUT_DW / OUT_W; k++) begin
      if (int'(d[k*OUT_W +: OUT_W]) < LO || int'(d[k*OUT_W +: OUT_W]) > HI) in_rng = 1'b0;
    end
  endfunction

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  wb_ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("ack missing one cycle after request");
  wb_ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  wb_ack_cause_a: assert property (wb_ack_o |-> $past(wb_stb_i))
    else $error("ack without request");
  wb_unmapped_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i
    && wb_adr_i >= 8'h38 |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  out_hold_a: assert property (dout_valid_o && !dout_ready_i |=> dout_valid_o
    && $stable(dout_data_o) && $stable(dout_sop_o) && $stable(dout_eop_o))
    else $error("output beat changed while stalled");
  out_range_a: assert property (dout_valid_o && vid_r |-> in_rng(dout_data_o))
    else $error("pixel outside output range");
  rst_quiet_a: assert property ($fell(rst_i) |-> !dout_valid_o && !wb_ack_o
    && !din_ready_o ##[1:2] din_ready_o) else $error("bad state after reset");
  pipe_lat_a: assert property (din_valid_i && din_ready_o
    |-> ##[1:3] dout_valid_o) else $error("pipeline latency too long");

  cover property (wb_cyc_i && wb_we_i && wb_ack_o);
  cover property (dout_valid_o && !dout_ready_i);
  cover property (dout_valid_o && dout_ready_i && dout_eop_o && vid_r);
endmodule

bind csc_core csc_chk #(.PARALLEL(PARALLEL), .IN_W(IN_W), .OUT_W(OUT_W), .OUT_GUARD(OUT_GUARD),
  .OUT_MIN(OUT_MIN), .OUT_MAX(OUT_MAX)) csc_chk_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .din_valid_i, .din_ready_o, .dout_data_o,
  .dout_valid_o, .dout_sop_o, .dout_eop_o, .dout_ready_i);

// ===== tb/csc_sink.sv
// Downstream stream sink with a stalling ready pattern
`timescale 1ns/10ps
module csc_sink #(
  parameter int W = 24
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         slow_i,
  input  wire logic [W-1:0] data_i,
  input  wire logic         valid_i,
  input  wire logic         sop_i,
  input  wire logic         eop_i,
  output logic              ready_o
);
  logic [W+1:0] got[$];
  logic [2:0]   cnt_r;

  // Slow mode stalls six cycles of eight, mid-packet too
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 3'h0;
      ready_o <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 3'h1;
      ready_o <= !slow_i || cnt_r == 3'h3 || cnt_r == 3'h6;
    end
  end

  always @(posedge clk_i) begin
    if (!rst_i && valid_i && ready_o) got.push_back({sop_i, eop_i, data_i});
  end
endmodule

// ===== tb/tb.sv
// Self-checking bench for the colour space converter
`timescale 1ns/10ps
module tb;
  import csc_pkg::*;
  localparam int OMIN = 16;
  localparam int OMAX = 235;
  localparam logic [31:0] CUST [12] = '{32'h00008000, 32'h00002080, 32'hFFFF8000,
    32'h00008000, 32'h00010000, 32'h00000000, 32'h00000000, 32'hFFFF0000, 32'h00010000,
    32'h00000000, 32'h00008000, 32'h00140000};
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [23:0] din_data_i = 24'h0;
  logic        din_valid_i = 1'b0;
  logic        din_sop_i = 1'b0;
  logic        din_eop_i = 1'b0;
  logic        din_ready_o;
  logic [23:0] dout_data_o;
  logic        dout_valid_o;
  logic        dout_sop_o;
  logic        dout_eop_o;
  logic        dout_ready_i;
  logic        slow = 1'b0;
  int          err_total = 0;
  int          n_compared = 0;
  int          r[12] = '{256, 0, 0, 0, 256, 0, 0, 0, 256, 0, 0, 0};
  logic [25:0] exp_q[$];
  logic [23:0] pix[$];

  // Unsigned types as presets need them, no scaling as widths match
  csc_core #(.PARALLEL(1'b1), .OUT_GUARD(1'b1), .RND_MODE(RND_HALF_EVEN),
    .OUT_MIN(OMIN), .OUT_MAX(OMAX), .SHIFT(0)) csc_core_i (.clk_i, .rst_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .din_data_i, .din_valid_i, .din_sop_i, .din_eop_i, .din_ready_o, .dout_data_o,
    .dout_valid_o, .dout_sop_o, .dout_eop_o, .dout_ready_i);
  csc_sink #(.W(24)) csc_sink_i (.clk_i, .rst_i, .slow_i(slow), .data_i(dout_data_o),
    .valid_i(dout_valid_o), .sop_i(dout_sop_o), .eop_i(dout_eop_o), .ready_o(dout_ready_i));

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  task summarize;
    if (err_total == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task tmo;
    $display("ERROR %0t wait timed out", $time);
    err_total++;
    summarize();
  endtask

  task check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) tmo();
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_dat_i <= ~dat;
    @(posedge clk_i);
  endtask

  // Reference: matrix product in 1/256 units, half even, clamp
  function automatic logic [7:0] conv(int k, logic [23:0] p);
    int a;
    int q;
    a = r[9+k];
    for (int j = 0; j < 3; j++) a += r[j*3+k] * int'(p[j*8 +: 8]);
    q = a >>> 8;
    if ((a & 255) > 128 || ((a & 255) == 128 && q[0])) q++;
    if (q < OMIN) q = OMIN;
    if (q > OMAX) q = OMAX;
    return q[7:0];
  endfunction

  task send_pkt(input logic [3:0] typ);
    int n;
    logic [23:0] b;
    for (int i = 0; i <= pix.size(); i++) begin
      b = (i == 0) ? {20'hA5C3B, typ} : pix[i-1];
      din_valid_i <= 1'b1;
      din_sop_i <= (i == 0);
      din_eop_i <= (i == pix.size());
      din_data_i <= b;
      exp_q.push_back({i == 0, i == pix.size(),
        (i == 0 || typ != PKT_VIDEO) ? b : {conv(2, b), conv(1, b), conv(0, b)}});
      n = 0;
      do begin
        @(posedge clk_i);
        n++;
      end while (din_ready_o !== 1'b1 && n < 200);
      if (n >= 200) tmo();
    end
    din_valid_i <= 1'b0;
    din_sop_i <= 1'b0;
    din_eop_i <= 1'b0;
    din_data_i <= ~b;
    pix.delete();
  endtask

  task drain;
    int n;
    n = 0;
    while (csc_sink_i.got.size() < exp_q.size() && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 2000) tmo();
    check(32'(csc_sink_i.got.size()), 32'(exp_q.size()));
    foreach (exp_q[i]) check(32'(csc_sink_i.got[i]), 32'(exp_q[i]));
    csc_sink_i.got.delete();
    exp_q.delete();
  endtask

  task t_reset_regs;
    logic [31:0] rd;
    wb(1'b0, 8'h00, 32'h0, rd);
    check(rd, 32'h00010000);
    wb(1'b0, 8'h04, 32'h0, rd);
    check(rd, 32'h0);
    wb(1'b0, ADR_CTRL, 32'h0, rd);
    check(rd, {28'h0, CTRL_RST});
    wb(1'b0, ADR_STAT, 32'h0, rd);
    check(rd, {PIXCNT_RST, 16'h0});
    wb(1'b0, 8'h40, 32'h0, rd);
    check(rd, 32'h0);
  endtask

  // Status after the packet: three pixels counted, outside video
  task t_identity;
    logic [31:0] rd;
    pix = '{24'hF08005, 24'h03EC64, 24'h101010};
    send_pkt(PKT_VIDEO);
    drain();
    wb(1'b0, ADR_STAT, 32'h0, rd);
    check(rd, {16'h0003, 16'h0000});
  endtask

  // Custom constants, one needing rounding, slow sink stalls mid-packet
  task t_custom;
    logic [31:0] rd;
    for (int i = 0; i < 12; i++) begin
      wb(1'b1, ADR_CONST0 + 8'(4 * i), CUST[i], rd);
      r[i] = (int'($signed(CUST[i])) + 128) >>> 8;
      wb(1'b0, ADR_CONST0 + 8'(4 * i), 32'h0, rd);
      check(rd, r[i] * 256);
    end
    slow <= 1'b1;
    pix = '{24'h000029, 24'h00002B, 24'h0AFAC8, 24'h642800, 24'h031E07, 24'hFFFFFF};
    send_pkt(PKT_VIDEO);
    drain();
    slow <= 1'b0;
  endtask

  // Other packet types pass as given, then header-only and one-pixel video packets
  task t_other;
    pix = '{24'h123456, 24'hFEDCBA};
    send_pkt(4'hF);
    @(posedge clk_i);
    send_pkt(PKT_VIDEO);
    @(posedge clk_i);
    pix = '{24'h0A0B0C};
    send_pkt(PKT_VIDEO);
    drain();
  endtask

  // Out-of-range preset number keeps constants but reads back custom
  task t_preset;
    logic [31:0] rd;
    wb(1'b1, ADR_CTRL, 32'h0000000C, rd);
    wb(1'b0, ADR_CTRL, 32'h0, rd);
    check(rd, 32'h0000000C);
    wb(1'b1, ADR_CTRL, 32'h0000000D, rd);
    wb(1'b0, ADR_CTRL, 32'h0, rd);
    check(rd, {28'h0000000, PRESET_CUSTOM});
    wb(1'b0, 8'h2C, 32'h0, rd);
    check(rd, 32'h0);
    r = '{12{0}};
    pix = '{24'h804020};
    send_pkt(PKT_VIDEO);
    drain();
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset_regs();
    t_identity();
    t_custom();
    t_other();
    t_preset();
    summarize();
  end
endmodule
